//--- rtl/acq_stop_ctrl.sv
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
module acq_stop_ctrl
    import acq_stop_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic [7:0]             address_i,
    input  wire logic                   read_i,
    input  wire logic                   write_i,
    input  wire logic [31:0]            writedata_i,
    input  wire logic [3:0]             byteenable_i,
    output logic      [31:0]            readdata_o,
    output logic                        waitrequest_o,
    input  wire logic                   acq_begin_trigger_i,
    input  wire logic                   analog_event_i,
    input  wire logic [LINES_N-1:0]     trigger_lines_i,
    input  wire logic [SAMPLE_W-1:0]    sample_data_i,
    output logic                        acq_sample_pulse_o,
    output logic                        acq_running_o,
    output logic                        acq_done_o,
    output logic [GEN_LINES_N-1:0]      general_trigger_line_o,
    output logic [GEN_LINES_N-1:0]      general_trigger_line_oe_o,
    output logic                        backplane_star_output_o
);

    // ========================================================
    // helpers
    function automatic logic [31:0] apply_be(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ========================================================
    // inputs from pins
    core_state_type      r_q;
    core_state_type      r_d;
    logic [SYNC_W-1:0]   sync_w;
    logic [SAMPLE_W-1:0] mem_rd;
    logic                begin_lvl;
    logic                ana_lvl;
    logic [LINES_N-1:0]  lines;
    logic                stop_lvl;
    logic                stop_edge;
    logic                pause_src_lvl;
    logic                pause_act;
    logic                running;
    logic                div_hit;
    logic                sample_tick;
    logic                stop_accept;
    logic                bus_take;
    logic                wr_en;
    logic                sw_start;
    logic                abort_req;
    logic                begin_req;
    logic [8:0]          post_target;
    logic [BUF_AW-1:0]   wr_next;

    line_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .async_i ({acq_begin_trigger_i, analog_event_i, trigger_lines_i}),
        .sync_o  (sync_w)
    );

    assign begin_lvl = sync_w[SYNC_W-1];
    assign ana_lvl   = sync_w[SYNC_W-2];
    assign lines     = sync_w[LINES_N-1:0];

    // ========================================================
    // trigger and pause decode
    assign stop_lvl = lines[r_q.cfg.stop_src];
    // previous level is tracked always, so a level already high at arm
    // time never counts as an edge
    assign stop_edge = r_q.cfg.stop_analog
        ? (ana_lvl & ~r_q.ana_prev)
        : (r_q.cfg.stop_falling ? (~stop_lvl & r_q.stop_prev)
                                : (stop_lvl & ~r_q.stop_prev));

    assign pause_src_lvl = (r_q.cfg.pause_src == PAUSE_ANALOG)
        ? ana_lvl : lines[r_q.cfg.pause_src[2:0]];
    assign pause_act = r_q.cfg.pause_en
        & (pause_src_lvl ^ r_q.cfg.pause_low);

    assign running = (r_q.st == ST_PRE) || (r_q.st == ST_ARMED)
        || (r_q.st == ST_POST);
    assign div_hit = ({1'b0, r_q.div_cnt} + 17'h0_0001)
        >= {1'b0, r_q.period};
    assign sample_tick = running & ~pause_act & div_hit;
    assign stop_accept = (r_q.st == ST_ARMED) & stop_edge;

    assign post_target = r_q.buf_size - r_q.pretrig;
    assign wr_next = ({1'b0, r_q.wr_ptr} == (r_q.buf_size - 9'h001))
        ? '0 : r_q.wr_ptr + 8'h01;

    // ========================================================
    // bus decode: every access gets exactly one wait state
    assign bus_take  = (read_i | write_i) & r_q.wait_q;
    assign wr_en     = bus_take & write_i;
    assign sw_start  = wr_en && (address_i == REG_CTRL) && byteenable_i[0]
        && writedata_i[CTRL_START_BIT];
    assign abort_req = wr_en && (address_i == REG_CTRL) && byteenable_i[0]
        && writedata_i[CTRL_ABORT_BIT];
    assign begin_req = (begin_lvl & ~r_q.begin_prev) | sw_start;

    sample_store u_store (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .wr_en_i   (sample_tick),
        .wr_addr_i (r_q.wr_ptr),
        .wr_data_i (sample_data_i),
        .rd_addr_i (r_q.rd_index),
        .rd_data_o (mem_rd)
    );

    // ========================================================
    // next state
    always_comb
    begin
        logic [31:0] wm;
        wm = '0;
        r_d = r_q;
        r_d.stop_prev  = stop_lvl;
        r_d.ana_prev   = ana_lvl;
        r_d.begin_prev = begin_lvl;
        r_d.sample_o   = sample_tick;
        r_d.line_o     = '0;
        r_d.star_o     = 1'b0;
        r_d.wait_q     = 1'b1;

        // paused divider holds its phase rather than restarting
        if (running && !pause_act)
        begin
            r_d.div_cnt = div_hit ? '0 : r_q.div_cnt + 16'h0001;
        end
        else if (!running)
        begin
            r_d.div_cnt = '0;
        end

        if (sample_tick)
        begin
            r_d.wr_ptr = wr_next;
        end

        case (r_q.st)
            ST_IDLE, ST_DONE:
            begin
                if (begin_req)
                begin
                    r_d.st = (r_q.pretrig == '0) ? ST_ARMED : ST_PRE;
                    r_d.wr_ptr    = '0;
                    r_d.pre_cnt   = '0;
                    r_d.post_cnt  = '0;
                    r_d.triggered = 1'b0;
                end
            end
            ST_PRE:
            begin
                if (sample_tick)
                begin
                    r_d.pre_cnt = r_q.pre_cnt + 9'h001;
                    if (r_q.pre_cnt + 9'h001 == r_q.pretrig)
                    begin
                        r_d.st = ST_ARMED;
                    end
                end
            end
            ST_ARMED:
            begin
                if (stop_accept)
                begin
                    r_d.triggered = 1'b1;
                    if (r_q.cfg.route_en)
                    begin
                        if (r_q.cfg.route_sel == ROUTE_STAR)
                        begin
                            r_d.star_o = 1'b1;
                        end
                        else if (!r_q.cfg.route_sel[4])
                        begin
                            r_d.line_o[r_q.cfg.route_sel[3:0]] = 1'b1;
                        end
                    end
                    if (post_target == '0)
                    begin
                        r_d.st     = ST_DONE;
                        r_d.oldest = sample_tick ? wr_next : r_q.wr_ptr;
                    end
                    else
                    begin
                        r_d.st = ST_POST;
                    end
                end
            end
            ST_POST:
            begin
                if (sample_tick)
                begin
                    r_d.post_cnt = r_q.post_cnt + 9'h001;
                    if (r_q.post_cnt + 9'h001 == post_target)
                    begin
                        r_d.st     = ST_DONE;
                        r_d.oldest = wr_next;
                    end
                end
            end
            default:
            begin
                r_d.st = ST_IDLE;
            end
        endcase

        if (abort_req)
        begin
            r_d.st = ST_IDLE;
        end

        r_d.line_oe = '0;
        if (r_q.cfg.route_en && !r_q.cfg.route_sel[4])
        begin
            r_d.line_oe[r_q.cfg.route_sel[3:0]] = 1'b1;
        end

        if (bus_take)
        begin
            r_d.wait_q = 1'b0;
            r_d.rdata  = '0;
            if (write_i)
            begin
                case (address_i)
                    REG_CONFIG:
                    begin
                        wm = apply_be(32'(r_q.cfg), writedata_i,
                            byteenable_i);
                        r_d.cfg = wm[CFG_W-1:0];
                    end
                    REG_BUF_SIZE:
                    begin
                        wm = apply_be(32'(r_q.buf_size), writedata_i,
                            byteenable_i);
                        r_d.buf_size = wm[8:0];
                    end
                    REG_PRETRIG:
                    begin
                        wm = apply_be(32'(r_q.pretrig), writedata_i,
                            byteenable_i);
                        r_d.pretrig = wm[8:0];
                    end
                    REG_PERIOD:
                    begin
                        wm = apply_be(32'(r_q.period), writedata_i,
                            byteenable_i);
                        r_d.period = wm[15:0];
                    end
                    REG_INDEX:
                    begin
                        wm = apply_be(32'(r_q.rd_index), writedata_i,
                            byteenable_i);
                        r_d.rd_index = wm[BUF_AW-1:0];
                    end
                    default:
                    begin
                        r_d.cfg = r_q.cfg;
                    end
                endcase
            end
            else
            begin
                case (address_i)
                    REG_CONFIG:   r_d.rdata = 32'(r_q.cfg);
                    REG_BUF_SIZE: r_d.rdata = 32'(r_q.buf_size);
                    REG_PRETRIG:  r_d.rdata = 32'(r_q.pretrig);
                    REG_PERIOD:   r_d.rdata = 32'(r_q.period);
                    REG_STATUS:   r_d.rdata = 32'({r_q.wr_ptr, 2'b00,
                        r_q.triggered, (r_q.st == ST_DONE), running,
                        r_q.st});
                    REG_OLDEST:   r_d.rdata = 32'(r_q.oldest);
                    REG_INDEX:    r_d.rdata = 32'(r_q.rd_index);
                    REG_DATA:     r_d.rdata = 32'(mem_rd);
                    default:      r_d.rdata = '0;
                endcase
            end
        end

        r_d.done_o    = (r_d.st == ST_DONE);
        r_d.running_o = (r_d.st == ST_PRE) || (r_d.st == ST_ARMED)
            || (r_d.st == ST_POST);
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r_q          <= '0;
            r_q.st       <= ST_IDLE;
            r_q.buf_size <= BUF_SIZE_RST;
            r_q.pretrig  <= PRETRIG_RST;
            r_q.period   <= PERIOD_RST;
            r_q.wait_q   <= 1'b1;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign readdata_o                = r_q.rdata;
    assign waitrequest_o             = r_q.wait_q;
    assign acq_sample_pulse_o        = r_q.sample_o;
    assign acq_running_o             = r_q.running_o;
    assign acq_done_o                = r_q.done_o;
    assign general_trigger_line_o    = r_q.line_o;
    assign general_trigger_line_oe_o = r_q.line_oe;
    assign backplane_star_output_o   = r_q.star_o;

    // ========================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_last_pre;
        r_q.st == ST_PRE && sample_tick
            && (r_q.pre_cnt + 9'h001 == r_q.pretrig) && !abort_req;
    endsequence

    sequence s_last_post;
        r_q.st == ST_POST && sample_tick
            && (r_q.post_cnt + 9'h001 == post_target) && !abort_req;
    endsequence

    a_arm_after_pre:
        assert property (s_last_pre |=> r_q.st == ST_ARMED)
        else $error("not armed after last pretrigger sample");
    a_post_done_oldest:
        assert property (s_last_post |=> r_q.st == ST_DONE
            && r_q.oldest == $past(wr_next) ##1 acq_done_o)
        else $error("posttrigger end or oldest position wrong");
    a_pre_ignores_stop:
        assert property (r_q.st == ST_PRE |=> r_q.st != ST_POST)
        else $error("stop trigger taken during pretrigger phase");
    a_no_retrigger:
        assert property (r_q.triggered |-> !stop_accept)
        else $error("stop trigger accepted twice");
    a_pause_gates:
        assert property (pause_act |=> !acq_sample_pulse_o)
        else $error("sample pulse while paused");
    a_idle_quiet:
        assert property (!running |=> !acq_sample_pulse_o)
        else $error("sample pulse outside acquisition");
    a_wrap_pointer:
        assert property (sample_tick
            && ({1'b0, r_q.wr_ptr} == r_q.buf_size - 9'h001)
            |=> r_q.wr_ptr == '0)
        else $error("write pointer did not wrap");
    a_route_star:
        assert property (stop_accept && r_q.cfg.route_en
            && r_q.cfg.route_sel == ROUTE_STAR
            |=> backplane_star_output_o ##1 !backplane_star_output_o)
        else $error("routed stop pulse missing or too long");
    a_begin_starts:
        assert property ((r_q.st == ST_IDLE || r_q.st == ST_DONE)
            && begin_req && !abort_req ##1 1'b1 |-> acq_running_o)
        else $error("acquisition did not start");
    a_analog_stop:
        assert property (r_q.st == ST_ARMED && r_q.cfg.stop_analog
            && ana_lvl && !r_q.ana_prev && !abort_req
            |=> r_q.st == ST_POST || r_q.st == ST_DONE)
        else $error("analog rising edge not taken as stop");
    a_falling_stop:
        assert property (r_q.st == ST_ARMED && !r_q.cfg.stop_analog
            && r_q.cfg.stop_falling && !stop_lvl && r_q.stop_prev
            && !abort_req |=> r_q.triggered)
        else $error("falling edge stop not taken");
    a_bus_answer:
        assert property ((read_i || write_i) && waitrequest_o
            |=> !waitrequest_o ##1 waitrequest_o)
        else $error("bus answer not one cycle");

endmodule

//--- rtl/acq_stop_pkg.sv
// Overview of operation
// - posttrigger count is buffer size minus pretrigger
// - arm stop trigger only after pretrigger samples
// - early stop trigger is ignored
// - full buffer wraps, overwriting oldest sample
// - stop after exactly posttrigger samples added
// - digital stop source selectable, rising or falling
// - analog stop on first rising event edge
// - accepted stop trigger optionally routed to line
// - pause active suppresses internal sample pulses
// - pause polarity and source are programmable
// - pause acts on level only
// - analog event can pause while low or high
// - no sample pulses outside an acquisition
// - stop trigger not retriggerable
// - start on begin trigger or software start
package acq_stop_pkg;

    // ========================================================
    // sizes
    localparam int BUF_AW      = 8;
    localparam int SAMPLE_W    = 16;
    localparam int LINES_N     = 8;
    localparam int GEN_LINES_N = 16;
    localparam int SYNC_W      = LINES_N + 2;

    // ========================================================
    // register map, byte addresses
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_CONFIG   = 8'h04;
    localparam logic [7:0] REG_BUF_SIZE = 8'h08;
    localparam logic [7:0] REG_PRETRIG  = 8'h0C;
    localparam logic [7:0] REG_PERIOD   = 8'h10;
    localparam logic [7:0] REG_STATUS   = 8'h14;
    localparam logic [7:0] REG_OLDEST   = 8'h18;
    localparam logic [7:0] REG_INDEX    = 8'h1C;
    localparam logic [7:0] REG_DATA     = 8'h20;

    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;

    // ========================================================
    // reset values and codes
    localparam logic [15:0] PERIOD_RST   = 16'h0004;
    localparam logic [8:0]  BUF_SIZE_RST = 9'h100;
    localparam logic [8:0]  PRETRIG_RST  = 9'h000;
    localparam logic [4:0]  ROUTE_STAR   = 5'h10;
    localparam logic [3:0]  PAUSE_ANALOG = 4'h8;

    // ========================================================
    // types
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'h0,
        ST_PRE   = 3'h1,
        ST_ARMED = 3'h3,
        ST_POST  = 3'h2,
        ST_DONE  = 3'h6
    } acq_state_type;

    typedef struct packed
    {
        logic       route_en;
        logic [4:0] route_sel;
        logic       pause_en;
        logic       pause_low;
        logic [3:0] pause_src;
        logic       stop_analog;
        logic       stop_falling;
        logic [2:0] stop_src;
    } cfg_type;

    localparam int CFG_W = $bits(cfg_type);

    typedef struct packed
    {
        acq_state_type          st;
        cfg_type                cfg;
        logic [8:0]             buf_size;
        logic [8:0]             pretrig;
        logic [15:0]            period;
        logic [15:0]            div_cnt;
        logic [BUF_AW-1:0]      wr_ptr;
        logic [8:0]             pre_cnt;
        logic [8:0]             post_cnt;
        logic [BUF_AW-1:0]      oldest;
        logic [BUF_AW-1:0]      rd_index;
        logic                   stop_prev;
        logic                   ana_prev;
        logic                   begin_prev;
        logic                   triggered;
        logic                   sample_o;
        logic                   done_o;
        logic                   running_o;
        logic [GEN_LINES_N-1:0] line_o;
        logic [GEN_LINES_N-1:0] line_oe;
        logic                   star_o;
        logic                   wait_q;
        logic [31:0]            rdata;
    } core_state_type;

endpackage

//--- rtl/line_sync.sv
module line_sync
    import acq_stop_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_type;

    sync_state_type r_q;
    sync_state_type r_d;

    always_comb
    begin
        r_d.s1 = async_i;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign sync_o = r_q.s2;

endmodule

//--- rtl/sample_store.sv
module sample_store
    import acq_stop_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire logic                wr_en_i,
    input  wire logic [BUF_AW-1:0]   wr_addr_i,
    input  wire logic [SAMPLE_W-1:0] wr_data_i,
    input  wire logic [BUF_AW-1:0]   rd_addr_i,
    output logic      [SAMPLE_W-1:0] rd_data_o
);

    // no reset on the array itself: keeps it mappable to block ram
    logic [SAMPLE_W-1:0] mem_q [0:(1<<BUF_AW)-1];
    logic [SAMPLE_W-1:0] rd_q;

    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rd_q <= '0;
        end
        else
        begin
            rd_q <= mem_q[rd_addr_i];
        end
    end

    assign rd_data_o = rd_q;

endmodule

//--- testbench/pretrigger_capture_pause_control_tb.sv
module pretrigger_capture_pause_control_tb;
    import acq_stop_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  address_i = 8'h00;
    logic        read_i = 1'b0;
    logic        write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0000_0000;
    logic [9:0]  lvl = 10'h000;
    logic [31:0] readdata_o, rd_q[$];
    logic        waitrequest_o, acq_sample_pulse_o, acq_running_o, acq_done_o;
    logic        star, analog_event_i, acq_begin_trigger_i;
    logic [7:0]  trigger_lines_i;
    logic [15:0] sample_data_i, gline, goe, line_seen;
    logic [31:0] rnd = 32'h0000_0049;
    int          miscompares = 0;
    int          n_checks = 0;
    int          n_pulse = 0;
    int          n_line = 0;
    int          n_star = 0;

    initial forever #2.5 clk_i = ~clk_i;

    acq_stop_ctrl dut (.clk_i, .reset_i, .address_i, .read_i, .write_i,
        .writedata_i, .byteenable_i(4'hf), .readdata_o, .waitrequest_o,
        .acq_begin_trigger_i, .analog_event_i, .trigger_lines_i,
        .sample_data_i, .acq_sample_pulse_o, .acq_running_o, .acq_done_o,
        .general_trigger_line_o(gline), .general_trigger_line_oe_o(goe),
        .backplane_star_output_o(star));

    trig_source_model model (.clk_i, .lvl_i(lvl),
        .pulse_i(acq_sample_pulse_o), .lines_o(trigger_lines_i),
        .event_o(analog_event_i), .begin_o(acq_begin_trigger_i),
        .data_o(sample_data_i));

    task automatic check(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic hang(input string what);
        miscompares++;
        $display("Error %s expected answer seen timeout", what);
        tally_and_finish();
    endtask

    // ==========
    // outputs sampled mid-cycle, where they are settled
    always @(negedge clk_i)
    begin
        if (acq_sample_pulse_o === 1'b1) n_pulse++;
        if (star === 1'b1) n_star++;
        if (gline !== 16'h0000)
        begin
            n_line++;
            line_seen = gline;
        end
    end

    // read data taken at the edge that samples waitrequest low
    always @(posedge clk_i)
        if (read_i === 1'b1 && waitrequest_o === 1'b0)
            check("readdata", rd_q.pop_front(), readdata_o);

    // for reads d is the expected word
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge clk_i);
        if (!wr) rd_q.push_back(d);
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= !wr;
        // request stands until the rising edge that sees waitrequest low
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk_i);
            if (waitrequest_o === 1'b0) break;
        end
        if (k == 20) hang("bus");
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask

    task automatic wait_pulses(input int n);
        for (int k = 0; k < 4000 && n_pulse < n; k++) @(negedge clk_i);
        if (n_pulse < n) hang("sample count");
    endtask

    task automatic stop_pulse(input int idx, input logic fall);
        @(posedge clk_i);
        lvl[idx] <= !fall;
        repeat (3) @(posedge clk_i);
        lvl[idx] <= fall;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // ==========
    initial
    begin
        int p, b, idx, sel;
        logic fall;
        int idx_t[3] = '{2, 6, 8};
        int sel_t[3] = '{3, 16, 9};
        repeat (8) @(posedge clk_i);
        check("wait in reset", 32'h0000_0001, waitrequest_o);
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        bus(0, REG_BUF_SIZE, 32'h0000_0100);
        bus(0, REG_PRETRIG, 32'h0000_0000);
        bus(0, REG_PERIOD, 32'h0000_0004);
        bus(0, REG_CONFIG, 32'h0000_0000);
        bus(1, 8'h30, 32'hffff_ffff);
        bus(0, 8'h30, 32'h0000_0000);
        repeat (3)
        begin
            rnd = xs(rnd);
            bus(1, REG_CONFIG, rnd & 32'h0001_ffff);
            bus(0, REG_CONFIG, rnd & 32'h0001_ffff);
        end
        p = n_pulse;
        repeat (50) @(posedge clk_i);
        check("idle pulses", p, n_pulse);
        $display("test registers done");
        for (int t = 0; t < 3; t++)
        begin
            idx = idx_t[t];
            sel = sel_t[t];
            fall = (t == 1);
            lvl[idx] <= fall;
            bus(1, REG_CONFIG, 32'h0001_0000 | (sel << 11) | ((idx >> 3) << 4)
                | (fall << 3) | (idx & 7));
            bus(1, REG_BUF_SIZE, 32'h0000_0008);
            bus(1, REG_PRETRIG, 32'h0000_0003);
            bus(1, REG_PERIOD, 32'h0000_0014);
            repeat (6) @(posedge clk_i);
            p = n_pulse;
            b = sample_data_i;
            n_line = 0;
            n_star = 0;
            if (t == 0)
            begin
                lvl[9] <= 1'b1;
                repeat (4) @(posedge clk_i);
                lvl[9] <= 1'b0;
            end
            else
                bus(1, REG_CTRL, 32'h0000_0001);
            wait_pulses(p + 1);
            stop_pulse(idx, fall);
            wait_pulses(p + 5);
            bus(0, REG_STATUS, 32'h0000_050b);
            stop_pulse(idx, fall);
            p = n_pulse;
            repeat (30) @(posedge clk_i);
            stop_pulse(idx, fall);
            // rising edge: the last pulse has already been counted
            for (int k = 0; k < 4000 && acq_done_o !== 1'b1; k++)
                @(posedge clk_i);
            if (acq_done_o !== 1'b1) hang("done");
            check("post samples", 5, n_pulse - p);
            check("line pulses", sel < 16, n_line);
            check("star pulses", sel == 16, n_star);
            if (sel < 16) check("line", 1 << sel, line_seen);
            check("line enable", sel < 16 ? 1 << sel : 0, goe);
            bus(0, REG_STATUS, 32'h0000_0236);
            bus(0, REG_OLDEST, 32'h0000_0002);
            bus(1, REG_INDEX, 32'h0000_0002);
            bus(0, REG_DATA, b + 2);
            bus(1, REG_INDEX, 32'h0000_0001);
            bus(0, REG_DATA, b + 9);
            bus(0, REG_INDEX, 32'h0000_0001);
            p = n_pulse;
            repeat (50) @(posedge clk_i);
            check("pulses after done", p, n_pulse);
            $display("test stop run %0d done", t);
        end
        for (int t = 0; t < 2; t++)
        begin
            lvl[5] <= (t == 0);
            lvl[8] <= 1'b0;
            bus(1, REG_CONFIG, t == 0 ? 32'h0000_04a0 : 32'h0000_0700);
            bus(1, REG_BUF_SIZE, 32'h0000_0100);
            bus(1, REG_PRETRIG, 32'h0000_0100);
            bus(1, REG_PERIOD, 32'h0000_0004);
            bus(1, REG_CTRL, 32'h0000_0001);
            repeat (10) @(posedge clk_i);
            check("running", 1, acq_running_o);
            p = n_pulse;
            repeat (100) @(posedge clk_i);
            check("paused pulses", p, n_pulse);
            lvl[5] <= 1'b0;
            lvl[8] <= 1'b1;
            repeat (100) @(posedge clk_i);
            check("resumed pulses", 1, (n_pulse - p) inside {[22:25]});
            bus(1, REG_CTRL, 32'h0000_0002);
            repeat (2) @(posedge clk_i);
            check("running after abort", 0, acq_running_o);
            $display("test pause %0d done", t);
        end
        tally_and_finish();
    end
endmodule

//--- testbench/trig_source_model.sv
// ==========
// far side: trigger pins and sample source
module trig_source_model
    import acq_stop_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic [9:0]          lvl_i,
    input  wire logic                pulse_i,
    output logic      [LINES_N-1:0]  lines_o,
    output logic                     event_o,
    output logic                     begin_o,
    output logic      [SAMPLE_W-1:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {lines_o, event_o, begin_o, data_o} = {10'h000, 16'h0a00};
    // pins lag the bench by a clock, so sync latency is exercised
    always @(posedge clk_i)
    begin
        lines_o <= lvl_i[7:0];
        event_o <= lvl_i[8];
        begin_o <= lvl_i[9];
        if (pulse_i)
        begin
            data_o <= data_o + 16'h0001;
        end
    end
endmodule
